// ==== wti_regs.vh ====
`ifndef WTI_REGS_VH
`define WTI_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define WTI_OFS_IRQ_CTRL    8'h00
`define WTI_OFS_P32_WAVE    8'h04
`define WTI_OFS_P54_WAVE    8'h08
`define WTI_OFS_P32_RELOAD  8'h0C
`define WTI_OFS_P54_RELOAD  8'h10
`define WTI_OFS_IRQ_STAT    8'h14
`define WTI_OFS_IRQ_MASK    8'h18

// ----------------------------------------------------------------------------
// Interrupt control register fields
// ----------------------------------------------------------------------------
`define WTI_P32_FLAG_BIT    8
`define WTI_P32_CLEAR_BIT   9
`define WTI_P32_START_BIT   10
`define WTI_P32_STOP_BIT    11
`define WTI_P54_FLAG_BIT    12
`define WTI_P54_CLEAR_BIT   13
`define WTI_P54_START_BIT   14
`define WTI_P54_STOP_BIT    15

// ----------------------------------------------------------------------------
// Wave control register fields
// ----------------------------------------------------------------------------
`define WTI_MODE_LSB        0
`define WTI_MODE_W          3
`define WTI_DIV_LSB         4
`define WTI_DIV_W           3
`define WTI_MODE_RELOAD0    3'h0
`define WTI_MODE_RELOAD1    3'h1

// ----------------------------------------------------------------------------
// Status and mask fields, reset values
// ----------------------------------------------------------------------------
`define WTI_STAT_P32_BIT    0
`define WTI_STAT_P54_BIT    1
`define WTI_RELOAD_W        16
`define WTI_RST_WAVE        16'h0000
`define WTI_RST_RELOAD      16'h0000
`define WTI_RST_MASK        2'h0

`endif

// ==== wti_timer.v ====
`timescale 1ns/1ps
`default_nettype none

module wti_timer #(
  parameter CW = 16,
  parameter DW = 3
) (
  // Clock, reset, enable
  input  wire          clock_i,
  input  wire          rst_n_i,
  input  wire          ce_i,
  // One-shot commands
  input  wire          start_i,
  input  wire          stop_i,
  input  wire          clear_i,
  // Configuration
  input  wire          mode_ok_i,
  input  wire [DW-1:0] div_sel_i,
  input  wire [CW-1:0] reload_i,
  // Status
  output wire          running_o,
  output wire          flag_o,
  output wire          event_o
);

  localparam PW = (1 << DW) - 1;

  reg          running_r;
  reg          flag_r;
  reg [CW-1:0] cnt_r;
  reg [PW-1:0] pre_r;
  wire [PW-1:0] pre_lim;
  wire          tick;

  // Prescaler limit gives 2^div cycles per count step
  assign pre_lim   = ~({PW{1'b1}} << div_sel_i);
  assign tick      = running_r & mode_ok_i & (pre_r == pre_lim);
  // Stop halts the count in the same cycle, so no event with it
  assign event_o   = tick & ~stop_i & (cnt_r <= {{(CW-1){1'b0}}, 1'b1});
  assign running_o = running_r;
  assign flag_o    = flag_r;

  // Run state, down-counter and flag
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      running_r <= 1'b0;
      flag_r    <= 1'b0;
      cnt_r     <= {CW{1'b0}};
      pre_r     <= {PW{1'b0}};
    end else if (ce_i) begin
      if (stop_i) begin
        running_r <= 1'b0;
        flag_r    <= 1'b0;
        pre_r     <= {PW{1'b0}};
      end else begin
        if (start_i && !running_r) begin
          running_r <= 1'b1;
          cnt_r     <= reload_i;
          pre_r     <= {PW{1'b0}};
        end else if (running_r && mode_ok_i) begin
          if (tick) begin
            pre_r <= {PW{1'b0}};
            if (event_o)
              cnt_r <= reload_i;
            else
              cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
          end else begin
            pre_r <= pre_r + {{(PW-1){1'b0}}, 1'b1};
          end
        end
        // Set wins over a clear in the same cycle
        if (event_o)
          flag_r <= 1'b1;
        else if (clear_i)
          flag_r <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ==== wti_irq.v ====
`timescale 1ns/1ps
`default_nettype none

module wti_irq #(
  parameter N = 2
) (
  // Clock, reset, enable
  input  wire         clock_i,
  input  wire         rst_n_i,
  input  wire         ce_i,
  // Events and software access
  input  wire [N-1:0] event_i,
  input  wire         wr_stat_i,
  input  wire         wr_mask_i,
  input  wire [N-1:0] wdata_i,
  // State
  output wire [N-1:0] status_o,
  output wire [N-1:0] mask_o,
  output wire         irq_o
);

  reg [N-1:0] status_r;
  reg [N-1:0] mask_r;
  reg [N-1:0] status_nxt;

  // Write one clears; a new event in the same cycle wins
  always @* begin
    status_nxt = status_r;
    if (wr_stat_i)
      status_nxt = status_nxt & ~wdata_i;
    status_nxt = status_nxt | event_i;
  end

  // Sticky status and mask
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_r <= {N{1'b0}};
      mask_r   <= {N{1'b0}};
    end else if (ce_i) begin
      status_r <= status_nxt;
      if (wr_mask_i)
        mask_r <= wdata_i;
    end
  end

  assign status_o = status_r;
  assign mask_o   = mask_r;
  assign irq_o    = |(status_r & mask_r);

endmodule

`default_nettype wire

// ==== wti_top.v ====
// Summary of operation
// - Writing one to bit 15 stops the pair-54 timer and clears its flag and line; zero does nothing; reads zero.
// - Writing one to bit 11 stops the pair-32 timer and clears its flag and line; zero does nothing; reads zero.
// - Bit 12 shows the pair-54 interrupt flag, read only, writes ignored.
// - Writing one to bit 13 clears the pair-54 flag and its line; zero does nothing; reads zero.
// - Writing one to bit 14 starts the pair-54 timer if stopped; the bit reads one while running.
// - Pair-32 flag, clear and start bits 8, 9 and 10 behave like the pair-54 ones.
// - The pair-32 timer counts and interrupts as a reload timer only with mode field 000 or 001.
// - The pair-54 timer counts and interrupts as a reload timer only with mode field 000 or 001.
// - A started timer loads the reload value, counts down, flags at count 1 and reloads at once.
// - The interrupt interval is the reload value shifted left by the division setting, in clock periods.
// - Stop beats clear and start when written together; clear and start written together both take effect.
// - A new reload value takes effect only at the next reload or start.
`timescale 1ns/1ps
`default_nettype none
`include "wti_regs.vh"

module wti_top #(
  parameter CW = `WTI_RELOAD_W,
  parameter DW = `WTI_DIV_W
) (
  // Clock, reset, enable
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire        ce_i,
  // Avalon-MM slave
  input  wire [7:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // Interrupts
  output wire        pair32_irq_o,
  output wire        pair54_irq_o,
  output wire        irq_o
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg          ack_r;
  reg [31:0]   rdata_r;
  reg [15:0]   p32_wave_r;
  reg [15:0]   p54_wave_r;
  reg [CW-1:0] p32_reload_r;
  reg [CW-1:0] p54_reload_r;
  reg [31:0]   rd_mux;

  wire         req;
  wire         wr_do;
  wire [31:0]  wmask;
  wire [31:0]  wbits;
  wire         wr_ctrl;
  wire         p32_run;
  wire         p54_run;
  wire         p32_flag;
  wire         p54_flag;
  wire         p32_evt;
  wire         p54_evt;
  wire [1:0]   irq_stat;
  wire [1:0]   irq_mask;
  wire [15:0]  ctrl_rd;

  // Command strobes and decoded conditions
  wire         p32_start_cmd;
  wire         p32_stop_cmd;
  wire         p32_clear_cmd;
  wire         p54_start_cmd;
  wire         p54_stop_cmd;
  wire         p54_clear_cmd;
  wire         p32_mode_ok;
  wire         p54_mode_ok;
  wire         wr_stat;
  wire         wr_mask;
  wire         rd_cap;

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------

  // Expand byte enables to a bit mask
  function [31:0] be_mask;
    input [3:0] be;
    begin
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // Mode field allows reload-timer use
  function mode_ok;
    input [15:0] wave;
    reg   [2:0]  m;
    begin
      m       = wave[`WTI_MODE_LSB +: `WTI_MODE_W];
      mode_ok = (m == `WTI_MODE_RELOAD0) || (m == `WTI_MODE_RELOAD1);
    end
  endfunction

  // Word-address match
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  // One-shot strobe from one bit of a control write
  function cmd_bit;
    input         wr;
    input [31:0]  data;
    input integer pos;
    begin
      cmd_bit = wr & data[pos];
    end
  endfunction

  // --------------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------------

  // One wait cycle per access; write acts at the edge where wait is low
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_r;
  assign wr_do             = ce_i & avs_write_i & ack_r;
  assign wmask             = be_mask(avs_byteenable_i);
  assign wbits             = avs_writedata_i & wmask;
  assign wr_ctrl           = wr_do & hit(avs_address_i, `WTI_OFS_IRQ_CTRL);
  assign avs_readdata_o    = rdata_r;

  // Acknowledge: high for the one cycle in which wait is low
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)
      ack_r <= 1'b0;
    else if (ce_i)
      ack_r <= req & ~ack_r;
  end

  // Read data captured in the wait cycle, standing while wait is low
  assign rd_cap = avs_read_i & ~ack_r;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)
      rdata_r <= 32'h00000000;
    else if (ce_i && rd_cap)
      rdata_r <= rd_mux;
  end

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------

  // Pair-32 wave control: mode field and clock division
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)
      p32_wave_r <= `WTI_RST_WAVE;
    else if (wr_do && hit(avs_address_i, `WTI_OFS_P32_WAVE))
      p32_wave_r <= (p32_wave_r & ~wmask[15:0]) | wbits[15:0];
  end

  // Pair-54 wave control: mode field and clock division
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)
      p54_wave_r <= `WTI_RST_WAVE;
    else if (wr_do && hit(avs_address_i, `WTI_OFS_P54_WAVE))
      p54_wave_r <= (p54_wave_r & ~wmask[15:0]) | wbits[15:0];
  end

  // Pair-32 reload value; a running count only sees it at its next reload
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)
      p32_reload_r <= `WTI_RST_RELOAD;
    else if (wr_do && hit(avs_address_i, `WTI_OFS_P32_RELOAD))
      p32_reload_r <= (p32_reload_r & ~wmask[CW-1:0]) | wbits[CW-1:0];
  end

  // Pair-54 reload value; a running count only sees it at its next reload
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)
      p54_reload_r <= `WTI_RST_RELOAD;
    else if (wr_do && hit(avs_address_i, `WTI_OFS_P54_RELOAD))
      p54_reload_r <= (p54_reload_r & ~wmask[CW-1:0]) | wbits[CW-1:0];
  end

  // Control readback: command bits read zero, flags and run state live
  assign ctrl_rd = {1'h0,
                    p54_run,
                    1'h0,
                    p54_flag,
                    1'h0,
                    p32_run,
                    1'h0,
                    p32_flag,
                    8'h00};

  // Read multiplexer; unmapped addresses read zero
  always @* begin
    rd_mux = 32'h00000000;
    if (hit(avs_address_i, `WTI_OFS_IRQ_CTRL))
      rd_mux[15:0] = ctrl_rd;
    else if (hit(avs_address_i, `WTI_OFS_P32_WAVE))
      rd_mux[15:0] = p32_wave_r;
    else if (hit(avs_address_i, `WTI_OFS_P54_WAVE))
      rd_mux[15:0] = p54_wave_r;
    else if (hit(avs_address_i, `WTI_OFS_P32_RELOAD))
      rd_mux[CW-1:0] = p32_reload_r;
    else if (hit(avs_address_i, `WTI_OFS_P54_RELOAD))
      rd_mux[CW-1:0] = p54_reload_r;
    else if (hit(avs_address_i, `WTI_OFS_IRQ_STAT))
      rd_mux[1:0] = irq_stat;
    else if (hit(avs_address_i, `WTI_OFS_IRQ_MASK))
      rd_mux[1:0] = irq_mask;
  end

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------

  // One-shot strobes from a control write; a zero bit does nothing
  assign p32_clear_cmd = cmd_bit(wr_ctrl, wbits, `WTI_P32_CLEAR_BIT);
  assign p32_start_cmd = cmd_bit(wr_ctrl, wbits, `WTI_P32_START_BIT);
  assign p32_stop_cmd  = cmd_bit(wr_ctrl, wbits, `WTI_P32_STOP_BIT);
  assign p54_clear_cmd = cmd_bit(wr_ctrl, wbits, `WTI_P54_CLEAR_BIT);
  assign p54_start_cmd = cmd_bit(wr_ctrl, wbits, `WTI_P54_START_BIT);
  assign p54_stop_cmd  = cmd_bit(wr_ctrl, wbits, `WTI_P54_STOP_BIT);

  // Reload-timer use only with the two permitted mode codes
  assign p32_mode_ok = mode_ok(p32_wave_r);
  assign p54_mode_ok = mode_ok(p54_wave_r);

  // Status and mask write strobes
  assign wr_stat = wr_do & hit(avs_address_i, `WTI_OFS_IRQ_STAT);
  assign wr_mask = wr_do & hit(avs_address_i, `WTI_OFS_IRQ_MASK);

  // --------------------------------------------------------------------------
  // Timers
  // --------------------------------------------------------------------------

  // Pair-32 reload timer
  wti_timer #(
    .CW (CW),
    .DW (DW)
  ) u_p32 (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .start_i   (p32_start_cmd),
    .stop_i    (p32_stop_cmd),
    .clear_i   (p32_clear_cmd),
    .mode_ok_i (p32_mode_ok),
    .div_sel_i (p32_wave_r[`WTI_DIV_LSB +: DW]),
    .reload_i  (p32_reload_r),
    .running_o (p32_run),
    .flag_o    (p32_flag),
    .event_o   (p32_evt)
  );

  // Pair-54 reload timer
  wti_timer #(
    .CW (CW),
    .DW (DW)
  ) u_p54 (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .start_i   (p54_start_cmd),
    .stop_i    (p54_stop_cmd),
    .clear_i   (p54_clear_cmd),
    .mode_ok_i (p54_mode_ok),
    .div_sel_i (p54_wave_r[`WTI_DIV_LSB +: DW]),
    .reload_i  (p54_reload_r),
    .running_o (p54_run),
    .flag_o    (p54_flag),
    .event_o   (p54_evt)
  );

  // Per-timer lines follow their flags
  assign pair32_irq_o = p32_flag;
  assign pair54_irq_o = p54_flag;

  // --------------------------------------------------------------------------
  // Summary interrupt
  // --------------------------------------------------------------------------

  // Sticky event status with mask
  wti_irq #(
    .N (2)
  ) u_irq (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .event_i   ({p54_evt, p32_evt}),
    .wr_stat_i (wr_stat),
    .wr_mask_i (wr_mask),
    .wdata_i   (wbits[1:0]),
    .status_o  (irq_stat),
    .mask_o    (irq_mask),
    .irq_o     (irq_o)
  );

endmodule

`default_nettype wire

// ==== wti_top_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module wti_top_chk #(
  parameter CW = 16,
  parameter DW = 3
) (
  // Clock, reset, enable
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  // Bus
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Interrupts
  input wire logic        pair32_irq_o,
  input wire logic        pair54_irq_o,
  input wire logic        irq_o
);
  // Accepted beats and control register hits
  wire acc    = (avs_read_i | avs_write_i) & ~avs_waitrequest_o & ce_i;
  wire ctl    = avs_address_i[7:2] == 6'h00;
  wire rd_ctl = acc & avs_read_i & ctl;
  wire wr_ctl = acc & avs_write_i & ctl & avs_byteenable_i[1];
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_p54_stop;
    wr_ctl && avs_writedata_i[15] |=> !pair54_irq_o;
  endproperty
  a_p54_stop: assert property (p_p54_stop) else $error("stop54 kept irq");
  property p_p32_stop;
    wr_ctl && avs_writedata_i[11] |=> !pair32_irq_o;
  endproperty
  a_p32_stop: assert property (p_p32_stop) else $error("stop32 kept irq");
  property p_p54_flag;
    rd_ctl |-> avs_readdata_o[12] == $past(pair54_irq_o);
  endproperty
  a_p54_flag: assert property (p_p54_flag) else $error("flag54 readback");
  property p_p32_flag;
    rd_ctl |-> avs_readdata_o[8] == $past(pair32_irq_o);
  endproperty
  a_p32_flag: assert property (p_p32_flag) else $error("flag32 readback");
  property p_w1_zero;
    rd_ctl |-> (avs_readdata_o & 32'hFFFFAAFF) == 32'h00000000;
  endproperty
  a_w1_zero: assert property (p_w1_zero) else $error("write-one bit read");
  property p_p54_fall;
    $fell(pair54_irq_o) |-> $past(wr_ctl && (avs_writedata_i[13] || avs_writedata_i[15]));
  endproperty
  a_p54_fall: assert property (p_p54_fall) else $error("irq54 fell alone");
  property p_p32_fall;
    $fell(pair32_irq_o) |-> $past(wr_ctl && (avs_writedata_i[9] || avs_writedata_i[11]));
  endproperty
  a_p32_fall: assert property (p_p32_fall) else $error("irq32 fell alone");
  property p_wait;
    ce_i && $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("wait cycle count");
  property p_unmap;
    acc && avs_read_i && avs_address_i[7:2] > 6'h06 |-> avs_readdata_o == 32'h00000000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  // Main scenarios
  c_p54: cover property ($rose(pair54_irq_o));
  c_p32: cover property ($rose(pair32_irq_o));
  c_irq: cover property ($rose(irq_o));
endmodule
bind wti_top wti_top_chk #(.CW(CW), .DW(DW)) u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .pair32_irq_o(pair32_irq_o),
  .pair54_irq_o(pair54_irq_o), .irq_o(irq_o));
`default_nettype wire

// ==== tb_waveform_timer_irq_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_waveform_timer_irq_control;
  // Design signals
  logic        clock_i;
  logic        rst_n_i;
  logic        ce_i;
  logic [7:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o;
  wire         pair32_irq_o;
  wire         pair54_irq_o;
  wire         irq_o;
  int          miscompares = 0;
  int          checks = 0;
  int          cyc = 0;
  int          ta, s, t1, t2, t3;
  logic [31:0] rd;
  wti_top u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .pair32_irq_o(pair32_irq_o),
    .pair54_irq_o(pair54_irq_o), .irq_o(irq_o));
  // Clock and cycle count
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  always @(posedge clock_i) cyc <= cyc + 1;
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    miscompares++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
  endtask
  // One access, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      fail("bus timeout");
      report_and_stop;
    end
    ta = cyc + 1;
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Waits for a timer line, returns its cycle stamp
  task automatic wait_irq(input int sel, output int t);
    int n;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while ((sel ? pair54_irq_o : pair32_irq_o) !== 1'b1 && n < 300);
    t = cyc;
    if (n >= 300) begin
      fail("irq timeout");
      report_and_stop;
    end
    @(posedge clock_i);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    for (int i = 0; i < 8; i++) rdc(8'(i * 4), 32'h0);
    wr(8'h1C, 32'hFFFF);
    rdc(8'h1C, 32'h0);
    $display("test reset done");
    wr(8'h08, 32'h30);
    wr(8'h10, 32'h3);
    wr(8'h00, 32'h4000);
    s = ta;
    rdc(8'h00, 32'h4000);
    wait_irq(1, t1);
    chk(t1 - s, 24);
    wr(8'h00, 32'h2000);
    chk(pair54_irq_o, 1'b0);
    wr(8'h10, 32'h5);
    wait_irq(1, t2);
    chk(t2 - t1, 24);
    rdc(8'h00, 32'h5000);
    wr(8'h00, 32'h1000);
    rdc(8'h00, 32'h5000);
    wr(8'h00, 32'h2000);
    wait_irq(1, t3);
    chk(t3 - t2, 40);
    wr(8'h00, 32'hE000);
    rdc(8'h00, 32'h0);
    repeat (60) @(negedge clock_i);
    chk(pair54_irq_o, 1'b0);
    @(posedge clock_i);
    $display("test pair54 done");
    wr(8'h04, 32'h2);
    wr(8'h0C, 32'h2);
    wr(8'h00, 32'h0400);
    rdc(8'h00, 32'h0400);
    repeat (20) @(negedge clock_i);
    chk(pair32_irq_o, 1'b0);
    @(posedge clock_i);
    wr(8'h04, 32'h1);
    wait_irq(0, t1);
    chk(t1 - ta, 2);
    rdc(8'h00, 32'h0500);
    wr(8'h00, 32'h0);
    rdc(8'h00, 32'h0500);
    wr(8'h00, 32'h0800);
    rdc(8'h00, 32'h0);
    chk(pair32_irq_o, 1'b0);
    $display("test pair32 done");
    rdc(8'h14, 32'h3);
    chk(irq_o, 1'b0);
    wr(8'h18, 32'h3);
    rdc(8'h18, 32'h3);
    chk(irq_o, 1'b1);
    wr(8'h14, 32'h1);
    rdc(8'h14, 32'h2);
    chk(irq_o, 1'b1);
    wr(8'h14, 32'h2);
    rdc(8'h14, 32'h0);
    chk(irq_o, 1'b0);
    $display("test irq done");
    wr(8'h00, 32'h4000);
    s = ta;
    ce_i <= 1'b0;
    repeat (16) @(posedge clock_i);
    ce_i <= 1'b1;
    wait_irq(1, t1);
    chk(t1 - s, 56);
    chk(irq_o, 1'b1);
    wr(8'h00, 32'h8000);
    rdc(8'h00, 32'h0);
    $display("test enable done");
    report_and_stop;
  end
endmodule
`default_nettype wire
